// ---- hdl/vsd_detect.sv ----
// vsd_detect: sd video standard detector top
// Summary of operation
// - bit six of the fourth symbol word is the h flag.
// - f, v and h are decoded from every timing symbol.
// - the s flag gives colour space, low rgb and high ycbcr.
// - p3, p2, p1 are xors of f, v, h and s.
// - p4 is checked as printed, v^v^h, which is h alone.
// - words between line starts are counted and compared to standards.
// - ntsc lines are 1716, 2288 and 3432 words.
// - pal lines are 1728, 2304 and 3456 words.
// - lock needs equal lines in a row; a few bad lines are ignored.
// - all-zero fourth word is composite, bit 9 set is component.
// - composite video keeps lock low and no standard reported.
`timescale 1ns/1ps
module vsd_detect #(
  parameter int unsigned LOCK_N = vsd_pkg::LOCK_LINES,
  parameter int unsigned MISS_N = vsd_pkg::MISS_LINES
) (
  input  wire logic       I_MCLK,
  input  wire logic       I_RSTN,
  input  wire logic       i_VLD,
  input  wire logic [9:0] i_WORD,
  output logic      [2:0] o_STD,
  output logic            o_LOCKED,
  output logic            o_COMPOSITE,
  output logic            o_FLAG_F,
  output logic            o_FLAG_V,
  output logic            o_FLAG_H,
  output logic            o_FLAG_S,
  output logic            o_PROT_ERR
);
  vsd_trs_if trs ();

  logic [11:0]          len;
  logic                 done;
  vsd_pkg::vsd_std_t    cls;
  vsd_pkg::vsd_std_t    cand_q;
  vsd_pkg::vsd_state_t  st_q;
  logic [3:0]           run_q;
  logic [3:0]           miss_q;

  vsd_trs_find u_find (
    .i_clk  (I_MCLK),
    .i_rstn (I_RSTN),
    .i_vld  (i_VLD),
    .i_word (i_WORD),
    .trs    (trs)
  );

  vsd_line_cnt #(.W(vsd_pkg::CNT_W)) u_cnt (
    .i_clk   (I_MCLK),
    .i_rstn  (I_RSTN),
    .i_vld   (i_VLD),
    .i_start (trs.line_start),
    .o_len   (len),
    .o_done  (done)
  );

  always_comb begin
    unique case (len)
      vsd_pkg::LEN_NTSC_43:   cls = vsd_pkg::VSD_NTSC_43;
      vsd_pkg::LEN_NTSC_169:  cls = vsd_pkg::VSD_NTSC_169;
      vsd_pkg::LEN_NTSC_4444: cls = vsd_pkg::VSD_NTSC_4444;
      vsd_pkg::LEN_PAL_43:    cls = vsd_pkg::VSD_PAL_43;
      vsd_pkg::LEN_PAL_169:   cls = vsd_pkg::VSD_PAL_169;
      vsd_pkg::LEN_PAL_4444:  cls = vsd_pkg::VSD_PAL_4444;
      default:                cls = vsd_pkg::VSD_NONE;
    endcase
  end

  // flags held from the last symbol
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      o_FLAG_F    <= 1'b0;
      o_FLAG_V    <= 1'b0;
      o_FLAG_H    <= 1'b0;
      o_FLAG_S    <= 1'b0;
      o_PROT_ERR  <= 1'b0;
      o_COMPOSITE <= 1'b0;
    end else if (trs.trs_seen) begin
      o_FLAG_F    <= trs.flag_f;
      o_FLAG_V    <= trs.flag_v;
      o_FLAG_H    <= trs.flag_h;
      o_FLAG_S    <= trs.flag_s;
      o_PROT_ERR  <= !trs.prot_ok && !trs.composite;
      o_COMPOSITE <= trs.composite;
    end
  end

  // lock filter, hunt then check then lock
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_q     <= vsd_pkg::VSD_HUNT;
      cand_q   <= vsd_pkg::VSD_NONE;
      run_q    <= 4'h0;
      miss_q   <= 4'h0;
      o_LOCKED <= 1'b0;
      o_STD    <= vsd_pkg::VSD_NONE;
    end else if (trs.trs_seen && trs.composite) begin
      st_q     <= vsd_pkg::VSD_HUNT;
      cand_q   <= vsd_pkg::VSD_NONE;
      run_q    <= 4'h0;
      miss_q   <= 4'h0;
      o_LOCKED <= 1'b0;
      o_STD    <= vsd_pkg::VSD_NONE;
    end else if (done) begin
      unique case (st_q)
        vsd_pkg::VSD_HUNT: begin
          if (cls != vsd_pkg::VSD_NONE) begin
            cand_q <= cls;
            run_q  <= 4'h1;
            st_q   <= vsd_pkg::VSD_CHECK;
          end
        end
        vsd_pkg::VSD_CHECK: begin
          if (cls == cand_q) begin
            if (32'(run_q) + 1 >= LOCK_N) begin
              st_q     <= vsd_pkg::VSD_LOCK;
              miss_q   <= 4'h0;
              o_LOCKED <= 1'b1;
              o_STD    <= cand_q;
            end
            run_q <= run_q + 4'h1;
          end else if (cls != vsd_pkg::VSD_NONE) begin
            cand_q <= cls;
            run_q  <= 4'h1;
          end else begin
            st_q  <= vsd_pkg::VSD_HUNT;
            run_q <= 4'h0;
          end
        end
        vsd_pkg::VSD_LOCK: begin
          if (cls == cand_q) begin
            miss_q <= 4'h0;
          end else if (32'(miss_q) + 1 >= MISS_N) begin
            // too many bad lines, start over
            st_q     <= vsd_pkg::VSD_HUNT;
            run_q    <= 4'h0;
            miss_q   <= 4'h0;
            o_LOCKED <= 1'b0;
            o_STD    <= vsd_pkg::VSD_NONE;
          end else begin
            miss_q <= miss_q + 4'h1;
          end
        end
        default: begin
          st_q     <= vsd_pkg::VSD_HUNT;
          o_LOCKED <= 1'b0;
          o_STD    <= vsd_pkg::VSD_NONE;
        end
      endcase
    end
  end

  // one measured line, against the current candidate
  sequence s_good_line;
    done && (cls == cand_q);
  endsequence
  sequence s_bad_line;
    done && (cls != cand_q);
  endsequence
  // composite symbol seen by the filter
  sequence s_comp_sym;
    trs.trs_seen && trs.composite;
  endsequence

  a_comp_unlock: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    s_comp_sym |=> !o_LOCKED && (o_STD == 3'h7))
    else $error("locked on composite");
  // lock only moves at line done or composite
  a_lock_bound: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    !$stable(o_LOCKED) |-> $past(done) || $past(trs.trs_seen))
    else $error("lock changed off boundary");
  // standard only moves together with lock
  a_std_bound: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    !$stable(o_STD) |-> !$stable(o_LOCKED))
    else $error("standard changed while lock held");
  a_std_none: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    !o_LOCKED |-> (o_STD == 3'h7))
    else $error("standard reported while unlocked");
  a_lock_rise: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    $rose(o_LOCKED) |-> $past(cls) == o_STD && $past(st_q) == 2'b01)
    else $error("lock rose without match");
  // a known length opens a check run
  a_hunt_start: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    (st_q == vsd_pkg::VSD_HUNT) && done && (cls != vsd_pkg::VSD_NONE)
    |=> (st_q == vsd_pkg::VSD_CHECK) && (run_q == 4'h1))
    else $error("hunt did not start a run");
  // a good line keeps lock and clears misses
  a_good_keep: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    o_LOCKED ##0 s_good_line |=> o_LOCKED && (miss_q == 4'h0))
    else $error("good line lost lock");
  // bad lines below the limit are tolerated
  a_miss_hold: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    (o_LOCKED && (32'(miss_q) + 1 < MISS_N)) ##0 s_bad_line |=> o_LOCKED)
    else $error("lock dropped before miss limit");
  // the miss limit of bad lines in a row unlocks
  a_miss_drop: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    (o_LOCKED && (32'(miss_q) + 1 >= MISS_N)) ##0 s_bad_line |=> !o_LOCKED)
    else $error("lock kept past miss limit");
  a_ntsc_len: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    len == 12'h6b4 |-> cls == vsd_pkg::VSD_NTSC_43)
    else $error("ntsc length not matched");
  a_pal_len: assert property (
    @(posedge I_MCLK) disable iff (!I_RSTN)
    len == 12'h900 |-> cls == vsd_pkg::VSD_PAL_169)
    else $error("pal length not matched");
endmodule // vsd_detect

// ---- hdl/vsd_pkg.sv ----
// vsd_pkg: constants and types shared by the standard detector files
package vsd_pkg;
  localparam int unsigned WORD_W = 10;
  localparam int unsigned CNT_W  = 12;
  // trs preamble words
  localparam logic [9:0] PRE_ONES  = 10'h3ff;
  localparam logic [9:0] PRE_ZEROS = 10'h000;
  // flag positions in the fourth trs word
  localparam int unsigned BIT_COMP = 9;
  localparam int unsigned BIT_F    = 8;
  localparam int unsigned BIT_V    = 7;
  localparam int unsigned BIT_H    = 6;
  localparam int unsigned BIT_S    = 5;
  localparam int unsigned BIT_P4   = 4;
  localparam int unsigned BIT_P3   = 3;
  localparam int unsigned BIT_P2   = 2;
  localparam int unsigned BIT_P1   = 1;
  // words per line
  localparam logic [11:0] LEN_NTSC_43   = 12'h6b4; // 1716
  localparam logic [11:0] LEN_NTSC_169  = 12'h8f0; // 2288
  localparam logic [11:0] LEN_NTSC_4444 = 12'hd68; // 3432
  localparam logic [11:0] LEN_PAL_43    = 12'h6c0; // 1728
  localparam logic [11:0] LEN_PAL_169   = 12'h900; // 2304
  localparam logic [11:0] LEN_PAL_4444  = 12'hd80; // 3456
  localparam int unsigned LOCK_LINES = 4;
  localparam int unsigned MISS_LINES = 4;
  typedef enum logic [2:0] {
    VSD_NTSC_43   = 3'h0,
    VSD_NTSC_169  = 3'h1,
    VSD_NTSC_4444 = 3'h2,
    VSD_PAL_43    = 3'h3,
    VSD_PAL_169   = 3'h4,
    VSD_PAL_4444  = 3'h5,
    VSD_NONE      = 3'h7
  } vsd_std_t;
  typedef enum logic [1:0] {
    VSD_HUNT  = 2'b00,
    VSD_CHECK = 2'b01,
    VSD_LOCK  = 2'b11
  } vsd_state_t;
endpackage

// ---- hdl/vsd_trs_if.sv ----
// vsd_trs_if: decoded timing symbol carried from finder to detector
`timescale 1ns/1ps
interface vsd_trs_if;
  logic       trs_seen;
  logic       line_start;
  logic       composite;
  logic       flag_f;
  logic       flag_v;
  logic       flag_h;
  logic       flag_s;
  logic       prot_ok;
  modport src (output trs_seen, line_start, composite, flag_f, flag_v,
               flag_h, flag_s, prot_ok);
  modport dst (input trs_seen, line_start, composite, flag_f, flag_v,
               flag_h, flag_s, prot_ok);
endinterface

// ---- hdl/vsd_trs_find.sv ----
// vsd_trs_find: timing symbol finder and flag decoder
`timescale 1ns/1ps
module vsd_trs_find (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_vld,
  input  wire logic [9:0] i_word,
  vsd_trs_if.src          trs
);
  logic [9:0] w1_q;
  logic [9:0] w2_q;
  logic [9:0] w3_q;
  logic       pre;
  logic       f;
  logic       v;
  logic       h;
  logic       s;

  assign pre = (w3_q == vsd_pkg::PRE_ONES) && (w2_q == vsd_pkg::PRE_ZEROS)
            && (w1_q == vsd_pkg::PRE_ZEROS) && i_vld;
  assign f = i_word[vsd_pkg::BIT_F];
  assign v = i_word[vsd_pkg::BIT_V];
  assign h = i_word[vsd_pkg::BIT_H];
  assign s = i_word[vsd_pkg::BIT_S];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      w1_q <= 10'h000;
      w2_q <= 10'h000;
      w3_q <= 10'h000;
    end else if (i_vld) begin
      w1_q <= i_word;
      w2_q <= w1_q;
      w3_q <= w2_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      trs.trs_seen   <= 1'b0;
      trs.line_start <= 1'b0;
      trs.composite  <= 1'b0;
      trs.flag_f     <= 1'b0;
      trs.flag_v     <= 1'b0;
      trs.flag_h     <= 1'b0;
      trs.flag_s     <= 1'b0;
      trs.prot_ok    <= 1'b0;
    end else begin
      trs.trs_seen <= pre;
      trs.line_start <= pre && i_word[vsd_pkg::BIT_COMP] && h;
      if (pre) begin
        // all zero composite, bit 9 component
        trs.composite <= (i_word == 10'h000);
        trs.flag_f    <= f;
        trs.flag_v    <= v;
        trs.flag_h    <= h;
        trs.flag_s    <= s;
        // p4 as printed, v^v^h reduces to h
        trs.prot_ok <= (i_word[vsd_pkg::BIT_P4] == (v ^ v ^ h))
                    && (i_word[vsd_pkg::BIT_P3] == (f ^ v ^ s))
                    && (i_word[vsd_pkg::BIT_P2] == (v ^ h ^ s))
                    && (i_word[vsd_pkg::BIT_P1] == (f ^ h ^ s));
      end
    end
  end

  // composite flag follows the all-zero word
  a_comp_class: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    pre |=> (trs.composite == ($past(i_word) == 10'h000)))
    else $error("composite class wrong");
  // line start only with h set
  a_eav_h: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    trs.line_start |-> $past(i_word[vsd_pkg::BIT_H]) && $past(pre))
    else $error("line start without h");
  a_prot_p1: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    pre && (i_word[vsd_pkg::BIT_P1] != (f ^ h ^ s)) |=> !trs.prot_ok)
    else $error("p1 mismatch accepted");
endmodule // vsd_trs_find

// ---- hdl/vsd_line_cnt.sv ----
// vsd_line_cnt: word counter between line starts
`timescale 1ns/1ps
module vsd_line_cnt #(
  parameter int unsigned W = 12
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_vld,
  input  wire logic         i_start,
  output logic     [W-1:0]  o_len,
  output logic              o_done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q  <= '0;
      o_len  <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= i_start;
      if (i_start) begin
        o_len <= cnt_q;
        // a stall right after the symbol must not count as a word
        cnt_q <= {{(W-1){1'b0}}, i_vld};
      end else if (i_vld && cnt_q != '1) begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end
endmodule // vsd_line_cnt

// ---- testbench/vsd_src_model.sv ----
// vsd_src_model: upstream framer model feeding aligned words
`timescale 1ns/1ps
module vsd_src_model (
  input  wire logic       i_clk,
  output logic            o_vld,
  output logic [9:0]      o_word
);
  initial begin
    o_vld  = 1'b0;
    o_word = 10'h155;
  end
  // one word, sometimes after a stall showing junk
  task automatic put(input logic [9:0] w);
    @(negedge i_clk);
    if ($urandom_range(7) == 0) begin
      o_vld  = 1'b0;
      o_word = ~o_word;
      @(negedge i_clk);
    end
    o_vld  = 1'b1;
    o_word = w;
  endtask
  task automatic sym(input logic [9:0] xyz);
    put(10'h3ff);
    put(10'h000);
    put(10'h000);
    put(xyz);
  endtask
  // filler never looks like a preamble word
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) begin
      put(10'(10'h004 + $urandom_range(1015)));
    end
  endtask
  task automatic stop();
    @(negedge i_clk);
    o_vld = 1'b0;
  endtask
endmodule // vsd_src_model

// ---- testbench/sdi_video_standard_detector_tb.sv ----
// sdi_video_standard_detector_tb: self-checking bench for vsd_detect
`timescale 1ns/1ps
module sdi_video_standard_detector_tb;
  localparam int unsigned LOCK_N = 2;
  localparam int unsigned MISS_N = 2;
  logic       mclk;
  logic       rstn;
  logic       vld;
  logic [9:0] word;
  logic [2:0] std_o;
  logic       locked;
  logic       comp;
  logic       ff;
  logic       fv;
  logic       fh;
  logic       fs;
  logic       perr;
  int         miscompares;
  int         total_checks;
  int         tbl[6] = '{1716, 2288, 3432, 1728, 2304, 3456};
  int         lens[$];
  int         n_eav, run, miss, cand;
  logic       exp_lock;
  logic [2:0] exp_std;

  vsd_src_model u_src (.i_clk(mclk), .o_vld(vld), .o_word(word));
  vsd_detect #(.LOCK_N(LOCK_N), .MISS_N(MISS_N)) i_dut (
    .I_MCLK(mclk), .I_RSTN(rstn), .i_VLD(vld), .i_WORD(word),
    .o_STD(std_o), .o_LOCKED(locked), .o_COMPOSITE(comp),
    .o_FLAG_F(ff), .o_FLAG_V(fv), .o_FLAG_H(fh), .o_FLAG_S(fs),
    .o_PROT_ERR(perr));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [9:0] mk(input logic f, v, h, s);
    return {1'b1, f, v, h, s, h, f ^ v ^ s, v ^ h ^ s, f ^ h ^ s, 1'b0};
  endfunction

  // unmatched lengths give code 7
  function automatic int std_of(input int len);
    for (int i = 0; i < 6; i++) if (tbl[i] == len) return i;
    return 7;
  endfunction

  task automatic model_clear();
    lens.delete();
    n_eav = 0; run = 0; miss = 0; cand = 7;
    exp_lock = 1'b0; exp_std = 3'h7;
  endtask

  task automatic do_reset();
    u_src.stop();
    rstn = 1'b0;
    model_clear();
    repeat (10) @(posedge mclk);
    chk({8'h0, locked, std_o}, 12'h007);
    @(negedge mclk);
    rstn = 1'b1;
  endtask

  // first measured length spans reset and is junk
  task automatic model_line();
    int m;
    n_eav++;
    if (n_eav < 2) return;
    m = std_of(lens[$]);
    if (exp_lock) begin
      miss = (m == exp_std) ? 0 : miss + 1;
      if (miss >= MISS_N) begin
        exp_lock = 1'b0; exp_std = 3'h7; run = 0;
      end
    end else begin
      run = (m != 7 && m == cand) ? run + 1 : int'(m != 7);
      cand = m;
      if (run >= LOCK_N) begin
        exp_lock = 1'b1; exp_std = 3'(m); miss = 0;
      end
    end
  endtask

  task automatic line(input int len);
    logic f, v, s, bad;
    model_line();
    lens.push_back(len);
    f = 1'($urandom_range(1)); v = 1'($urandom_range(1));
    s = 1'($urandom_range(1));
    u_src.sym(mk(f, v, 1'b1, s));
    u_src.fill(4);
    chk({6'h0, comp, ff, fv, fh, fs, perr}, {7'h0, f, v, 1'b1, s, 1'b0});
    f = ~f; s = ~s; bad = ($urandom_range(3) == 0);
    u_src.sym(mk(f, v, 1'b0, s) ^ {8'h0, bad, 1'b0});
    u_src.fill(4);
    chk({6'h0, comp, ff, fv, fh, fs, perr}, {7'h0, f, v, 1'b0, s, bad});
    u_src.fill(len - 16);
    chk({8'h0, locked, std_o}, {8'h0, exp_lock, exp_std});
  endtask

  initial begin
    rstn = 1'b0;
    miscompares = 0;
    total_checks = 0;
    model_clear();
    void'($urandom(32'h2ae2f0b2));
    for (int c = 0; c < 6; c++) begin
      do_reset();
      repeat (LOCK_N + 2) line(tbl[c]);
    end
    do_reset();
    repeat (LOCK_N + 2) line(tbl[3]);
    line(1800);
    line(tbl[3]);
    line(1800);
    line(1800);
    repeat (3) line(tbl[3]);
    u_src.sym(10'h000);
    u_src.fill(8);
    chk({7'h0, comp, locked, std_o}, 12'h017);
    model_clear();
    line(tbl[3]);
    u_src.stop();
    end_of_test();
  end

  initial begin
    #2_000_000;
    miscompares++;
    end_of_test();
  end
endmodule // sdi_video_standard_detector_tb
